// ### swt_params.svh
// Register indices, field positions, reset values and timing figures of the stopwatch timer
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define SWT_IDX_PRIO 16'hFF20
`define SWT_IDX_EN 16'hFF22
`define SWT_IDX_FLAG 16'hFF24
`define SWT_IDX_CTRL 16'hFF42
`define SWT_IDX_COUNT 16'hFF43
`define SWT_IDX_W 16
`define SWT_ADR_HI_ZERO 14'h0000

// Field positions
`define SWT_RUN_BIT 0
`define SWT_CLR_BIT 1
`define SWT_PRIO_LSB 2
`define SWT_PRIO_MSB 3
`define SWT_FACT_LSB 4
`define SWT_FACT_MSB 6

// Factor order inside the factor fields
`define SWT_F_ONE 0
`define SWT_F_TEN 1
`define SWT_F_HUN 2

// Reset values
`define SWT_COUNT_RST 8'h00
`define SWT_PRIO_RST 2'h0
`define SWT_FACT_RST 3'h0
`define SWT_DAT_RST 32'h0000_0000

// BCD digit limits
`define SWT_BCD_MAX 4'h9
`define SWT_BCD_ZERO 4'h0

// Timing: clock rate and the two timing sources, in Hz
`define SWT_CLK_HZ 25000000
`define SWT_FAST_HZ 256
`define SWT_CNT_HZ 100
`define SWT_DIV_W 18

`endif

// ### swt_pkg.sv
// Types shared by the stopwatch timer design
`default_nettype none
package swt_pkg;

  typedef enum logic [2:0] {
    SWT_STOPPED  = 3'h1,
    SWT_RUNNING  = 3'h2,
    SWT_STOPPING = 3'h4
  } swt_run_t;

  typedef logic [1:0] swt_prio_t;
  typedef logic [2:0] swt_fact_t;
  typedef logic [7:0] swt_count_t;

endpackage : swt_pkg
`default_nettype wire

// ### swt_top.sv
// Stopwatch timer: BCD count, run control, factor flags and Wishbone register slave
// Overview of operation
// - Count reads as one byte: low nibble hundredths, high nibble tenths; writes ignored.
// - Reset clears the count byte to zero.
// - Writing one to clear resets the count; zero does nothing; clear reads zero.
// - Clear while running keeps counting from zero; while stopped zero is held.
// - Readable run bit: one counts upward, zero stops.
// - Stopped count holds until cleared; running again continues from it.
// - Two-bit priority field gives levels 3 to 0; 0 means none; resets to 0.
// - Three enable bits for 1, 10 and 100 Hz factors; reset disabled.
// - Each factor flag sets on the falling edge of its divided signal.
// - Flags set regardless of enables and priority.
// - Interrupt requested when an enabled flag is set and priority exceeds CPU mask.
// - Writing one clears a flag, zero does nothing; flags reset to zero.
// - Run bit writes take effect at the next 256 Hz falling edge.
// - After run is written zero, one more count, run reads one until stopped.
`timescale 1ns/1ns
`default_nettype none
`include "swt_params.svh"

module swt_top #(
  parameter int P_DIV_CNT = `SWT_CLK_HZ / `SWT_CNT_HZ,
  parameter int P_DIV_FAST = `SWT_CLK_HZ / `SWT_FAST_HZ
) (
  input wire logic i_mclk,           // System clock, 25 MHz
  input wire logic i_rstn,           // Asynchronous reset, active low
  input wire logic i_wb_cyc,         // Wishbone cycle
  input wire logic i_wb_stb,         // Wishbone strobe
  input wire logic i_wb_we,          // Wishbone write enable
  input wire logic [31:0] i_wb_adr,  // Wishbone byte address
  input wire logic [3:0] i_wb_sel,   // Wishbone byte selects
  input wire logic [31:0] i_wb_dat,  // Wishbone write data
  input wire logic i_cpu_mask_lo,    // CPU interrupt mask level, low bit
  input wire logic i_cpu_mask_hi,    // CPU interrupt mask level, high bit
  output logic [31:0] o_wb_dat,      // Wishbone read data
  output logic o_wb_ack,             // Wishbone acknowledge
  output logic o_irq,                // Level: enabled factor flag set
  output logic o_irq_req,            // Level: request above CPU mask
  output logic [1:0] o_irq_level     // Priority of the pending request
);

  localparam logic [`SWT_DIV_W-1:0] LP_CNT_LAST = `SWT_DIV_W'(P_DIV_CNT - 1);
  localparam logic [`SWT_DIV_W-1:0] LP_FAST_LAST = `SWT_DIV_W'(P_DIV_FAST - 1);

  // Bus decode
  logic req;
  logic wr;
  logic hit;
  logic [`SWT_IDX_W-1:0] idx;
  logic wr_prio;
  logic wr_en;
  logic wr_flag;
  logic wr_ctrl;
  logic clr;

  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign hit = (i_wb_adr[31:18] == `SWT_ADR_HI_ZERO);
  assign idx = i_wb_adr[17:2];
  assign wr = req & i_wb_we & i_wb_sel[0] & hit;
  assign wr_prio = wr & (idx == `SWT_IDX_PRIO);
  assign wr_en = wr & (idx == `SWT_IDX_EN);
  assign wr_flag = wr & (idx == `SWT_IDX_FLAG);
  assign wr_ctrl = wr & (idx == `SWT_IDX_CTRL);
  assign clr = wr_ctrl & i_wb_dat[`SWT_CLR_BIT];

  // Timing sources: one-cycle ticks mark the falling edges of the divided signals
  logic [`SWT_DIV_W-1:0] div_cnt_q;
  logic [`SWT_DIV_W-1:0] div_cnt_d;
  logic [`SWT_DIV_W-1:0] div_fast_q;
  logic [`SWT_DIV_W-1:0] div_fast_d;
  logic tick_cnt;
  logic tick_fast;

  assign tick_cnt = (div_cnt_q == LP_CNT_LAST);
  assign tick_fast = (div_fast_q == LP_FAST_LAST);

  always_comb begin
    div_cnt_d = div_cnt_q + `SWT_DIV_W'(1);
    if (tick_cnt || clr) begin
      // Clearing restarts the hundredths period as well
      div_cnt_d = '0;
    end
    div_fast_d = div_fast_q + `SWT_DIV_W'(1);
    if (tick_fast) begin
      div_fast_d = '0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt_q <= '0;
      div_fast_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_d;
      div_fast_q <= div_fast_d;
    end
  end

  // Run control
  swt_pkg::swt_run_t state_q;
  swt_pkg::swt_run_t state_d;
  logic run_req_q;
  logic run_req_d;
  logic active;
  logic run_rd;

  assign active = (state_q != swt_pkg::SWT_STOPPED);
  assign run_rd = run_req_q | active;

  always_comb begin
    run_req_d = run_req_q;
    if (wr_ctrl) begin
      run_req_d = i_wb_dat[`SWT_RUN_BIT];
    end
    state_d = state_q;
    case (state_q)
      swt_pkg::SWT_STOPPED: begin
        if (tick_fast && run_req_q) begin
          state_d = swt_pkg::SWT_RUNNING;
        end
      end
      swt_pkg::SWT_RUNNING: begin
        if (tick_fast && !run_req_q) begin
          state_d = swt_pkg::SWT_STOPPING;
        end
      end
      swt_pkg::SWT_STOPPING: begin
        if (tick_cnt) begin
          // The last count still happens in this cycle
          state_d = swt_pkg::SWT_STOPPED;
        end else if (tick_fast && run_req_q) begin
          state_d = swt_pkg::SWT_RUNNING;
        end
      end
      default: begin
        state_d = swt_pkg::SWT_STOPPED;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= swt_pkg::SWT_STOPPED;
      run_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      run_req_q <= run_req_d;
    end
  end

  // BCD count and factor events
  swt_pkg::swt_count_t count_q;
  swt_pkg::swt_count_t count_d;
  swt_pkg::swt_fact_t ev;
  logic step;
  logic lo_wrap;
  logic hi_wrap;

  assign step = tick_cnt & active & ~clr;
  assign lo_wrap = (count_q[3:0] == `SWT_BCD_MAX);
  assign hi_wrap = (count_q[7:4] == `SWT_BCD_MAX);
  assign ev[`SWT_F_HUN] = step;
  assign ev[`SWT_F_TEN] = step & lo_wrap;
  assign ev[`SWT_F_ONE] = step & lo_wrap & hi_wrap;

  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = `SWT_COUNT_RST;
    end else if (step) begin
      if (lo_wrap) begin
        count_d[3:0] = `SWT_BCD_ZERO;
        count_d[7:4] = hi_wrap ? `SWT_BCD_ZERO : count_q[7:4] + 4'h1;
      end else begin
        count_d[3:0] = count_q[3:0] + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_q <= `SWT_COUNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  // Priority, enables and factor flags
  swt_pkg::swt_prio_t prio_q;
  swt_pkg::swt_prio_t prio_d;
  swt_pkg::swt_fact_t en_q;
  swt_pkg::swt_fact_t en_d;
  swt_pkg::swt_fact_t flag_q;
  swt_pkg::swt_fact_t flag_d;

  always_comb begin
    prio_d = prio_q;
    en_d = en_q;
    if (wr_prio) begin
      prio_d = i_wb_dat[`SWT_PRIO_MSB:`SWT_PRIO_LSB];
    end
    if (wr_en) begin
      en_d = i_wb_dat[`SWT_FACT_MSB:`SWT_FACT_LSB];
    end
  end

  // A new event wins over a clear written in the same cycle
  for (genvar k = 0; k < 3; k++) begin : g_flag
    always_comb begin
      flag_d[k] = ev[k] | (flag_q[k] & ~(wr_flag & i_wb_dat[`SWT_FACT_LSB + k]));
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      prio_q <= `SWT_PRIO_RST;
      en_q <= `SWT_FACT_RST;
      flag_q <= `SWT_FACT_RST;
    end else begin
      prio_q <= prio_d;
      en_q <= en_d;
      flag_q <= flag_d;
    end
  end

  // Interrupt outputs
  logic irq_d;
  logic irq_req_d;
  logic [1:0] irq_level_d;

  always_comb begin
    irq_d = |(flag_q & en_q);
    irq_req_d = irq_d && (prio_q > {i_cpu_mask_hi, i_cpu_mask_lo});
    irq_level_d = irq_req_d ? prio_q : `SWT_PRIO_RST;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
      o_irq_req <= 1'b0;
      o_irq_level <= `SWT_PRIO_RST;
    end else begin
      o_irq <= irq_d;
      o_irq_req <= irq_req_d;
      o_irq_level <= irq_level_d;
    end
  end

  // Read data and acknowledge; unmapped addresses answer with zero
  logic [31:0] rd_d;
  logic ack_d;

  always_comb begin
    rd_d = `SWT_DAT_RST;
    if (hit) begin
      case (idx)
        `SWT_IDX_PRIO: rd_d[`SWT_PRIO_MSB:`SWT_PRIO_LSB] = prio_q;
        `SWT_IDX_EN: rd_d[`SWT_FACT_MSB:`SWT_FACT_LSB] = en_q;
        `SWT_IDX_FLAG: rd_d[`SWT_FACT_MSB:`SWT_FACT_LSB] = flag_q;
        `SWT_IDX_CTRL: rd_d[`SWT_RUN_BIT] = run_rd;
        `SWT_IDX_COUNT: rd_d[7:0] = count_q;
        default: rd_d = `SWT_DAT_RST;
      endcase
    end
    ack_d = req;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `SWT_DAT_RST;
    end else begin
      o_wb_ack <= ack_d;
      o_wb_dat <= ack_d ? rd_d : `SWT_DAT_RST;
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  AST_COUNT_ONLY_STEPS:
  assert property ((count_q != $past(count_q)) |-> $past(step || clr))
    else $error("count changed without a tick or clear");

  AST_CLEAR_ZERO:
  assert property (clr |=> count_q == `SWT_COUNT_RST)
    else $error("count not zero after clear");

  AST_CLR_READS_ZERO:
  assert property ((req && !i_wb_we && hit && idx == `SWT_IDX_CTRL) |=> o_wb_ack && !o_wb_dat[`SWT_CLR_BIT])
    else $error("clear bit read as one or no ack");

  AST_RUN_ON_TICK:
  assert property ((state_q != $past(state_q)) |-> $past(tick_fast || tick_cnt))
    else $error("run state moved off the timing edges");

  AST_RUN_READS_ONE:
  assert property ((req && !i_wb_we && hit && idx == `SWT_IDX_CTRL && state_q != swt_pkg::SWT_STOPPED)
                   |=> o_wb_dat[`SWT_RUN_BIT])
    else $error("run bit reads zero before the stop");

  AST_LAST_COUNT:
  assert property ((state_q == swt_pkg::SWT_STOPPING && tick_cnt && !clr)
                   |=> state_q == swt_pkg::SWT_STOPPED && count_q != $past(count_q))
    else $error("stop without the final count");

  AST_FLAG_SET:
  assert property (step |=> flag_q[`SWT_F_HUN])
    else $error("100 Hz flag missed");

  AST_FLAG_W1C:
  assert property ((wr_flag && i_wb_dat[`SWT_FACT_LSB] && !ev[`SWT_F_ONE]) |=> !flag_q[`SWT_F_ONE])
    else $error("1 Hz flag not cleared by a one");

  AST_IRQ_REQ:
  assert property ((|(flag_q & en_q) && prio_q > {i_cpu_mask_hi, i_cpu_mask_lo}) |=> o_irq_req ##0 o_irq_level == $past(prio_q))
    else $error("interrupt request missing");

  AST_BCD_RANGE:
  assert property (count_q[3:0] <= `SWT_BCD_MAX && count_q[7:4] <= `SWT_BCD_MAX)
    else $error("count digit out of BCD range");

  AST_COUNT_RO:
  assert property ((wr && idx == `SWT_IDX_COUNT && !step) |=> count_q == $past(count_q))
    else $error("count byte changed by a write");

  AST_STOPPED_HOLDS:
  assert property ((state_q == swt_pkg::SWT_STOPPED && !clr) |=> count_q == $past(count_q))
    else $error("count moved while stopped");

  AST_START_ON_TICK:
  assert property ((state_q == swt_pkg::SWT_STOPPED && tick_fast && run_req_q) |=> state_q == swt_pkg::SWT_RUNNING)
    else $error("run request not taken at the timing edge");

  AST_STOP_ON_TICK:
  assert property ((state_q == swt_pkg::SWT_RUNNING && tick_fast && !run_req_q) |=> state_q == swt_pkg::SWT_STOPPING)
    else $error("stop request not taken at the timing edge");

  AST_TEN_HZ:
  assert property ((step && lo_wrap) |=> flag_q[`SWT_F_TEN])
    else $error("10 Hz flag missed on the hundredths carry");

  AST_ONE_HZ:
  assert property ((step && lo_wrap && hi_wrap) |=> flag_q[`SWT_F_ONE] && count_q == `SWT_COUNT_RST)
    else $error("1 Hz flag or wrap to zero missed");

  AST_PRIO_WRITE:
  assert property (wr_prio |=> prio_q == $past(i_wb_dat[`SWT_PRIO_MSB:`SWT_PRIO_LSB]))
    else $error("priority field not written");

  AST_EN_WRITE:
  assert property (wr_en |=> en_q == $past(i_wb_dat[`SWT_FACT_MSB:`SWT_FACT_LSB]))
    else $error("enable bits not written");

  AST_LEVEL0_NO_REQ:
  assert property ((prio_q == `SWT_PRIO_RST) |=> !o_irq_req)
    else $error("request raised at priority level 0");

  AST_FLAG_HOLD:
  assert property ((flag_q[`SWT_F_HUN] && !wr_flag) |=> flag_q[`SWT_F_HUN])
    else $error("100 Hz flag dropped without a write");

  COV_START: cover property (state_q == swt_pkg::SWT_STOPPED ##1 state_q == swt_pkg::SWT_RUNNING);
  COV_STOP: cover property (state_q == swt_pkg::SWT_STOPPING ##1 state_q == swt_pkg::SWT_STOPPED);
  COV_ONE_HZ: cover property (ev[`SWT_F_ONE]);
  COV_IRQ_REQ: cover property (o_irq_req);
  COV_CLEAR_RUNNING: cover property (clr && state_q == swt_pkg::SWT_RUNNING);

endmodule : swt_top

`default_nettype wire

// ### swt_cpu_model.sv
// CPU-side interrupt model: holds the mask level and accepts requests
`timescale 1ns/1ns
`default_nettype none
module swt_cpu_model (
  input wire logic i_mclk,            // Clock
  input wire logic i_rstn,            // Reset, active low
  input wire logic i_irq_req,         // Request from the stopwatch
  input wire logic [1:0] i_irq_level, // Level of the request
  input wire logic i_mask_wr,         // Software rewrites the mask
  input wire logic [1:0] i_mask,      // New mask level
  output logic o_mask_lo,             // Mask level, low bit
  output logic o_mask_hi,             // Mask level, high bit
  output var int o_taken              // Interrupts accepted
);
  logic [1:0] mask_q;
  assign o_mask_lo = mask_q[0];
  assign o_mask_hi = mask_q[1];
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_q <= 2'h0;
      o_taken <= 0;
    end else if (i_mask_wr) begin
      mask_q <= i_mask;
    end else if (i_irq_req && i_irq_level > mask_q) begin
      // Accepting raises the mask to the request level, blocking a repeat
      mask_q <= i_irq_level;
      o_taken <= o_taken + 1;
    end
  end
endmodule : swt_cpu_model
`default_nettype wire

// ### swt_top_tb.sv
// Self-checking testbench of the stopwatch timer
`timescale 1ns/1ns
`default_nettype none
`include "swt_params.svh"
module swt_top_tb;
  localparam logic [15:0] pri = `SWT_IDX_PRIO;
  localparam logic [15:0] ena = `SWT_IDX_EN;
  localparam logic [15:0] flg = `SWT_IDX_FLAG;
  localparam logic [15:0] ctl = `SWT_IDX_CTRL;
  localparam logic [15:0] cnt = `SWT_IDX_COUNT;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic mask_wr = 1'b0;
  logic [1:0] mask = 2'h0;
  logic [31:0] rdat;
  logic ack, irq, req, mlo, mhi;
  logic [1:0] lvl;
  logic [7:0] rv, c0;
  int taken;
  int err_total = 0;
  int num_checks = 0;
  always #20 mclk = ~mclk;
  swt_top #(.P_DIV_CNT(40), .P_DIV_FAST(4)) dut_u (.i_mclk(mclk), .i_rstn(rstn),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .i_cpu_mask_lo(mlo), .i_cpu_mask_hi(mhi), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_irq(irq), .o_irq_req(req), .o_irq_level(lvl));
  swt_cpu_model cpu_u (.i_mclk(mclk), .i_rstn(rstn), .i_irq_req(req), .i_irq_level(lvl),
    .i_mask_wr(mask_wr), .i_mask(mask), .o_mask_lo(mlo), .o_mask_hi(mhi), .o_taken(taken));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {14'h0000, idx, 2'h0};
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rv = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("MISMATCH t=%0t no ack", $time);
      test_done();
    end
  endtask : wb
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input string what);
    wb(1'b0, idx, 8'h00);
    chk(rv, exp, what);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask : ticks
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] != 4'h9) return v + 8'h01;
    if (v[7:4] != 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return 8'h00;
  endfunction : bcd_inc
  task automatic t_reset();
    rd(pri, 8'h00, "prio");
    rd(ena, 8'h00, "enables");
    rd(flg, 8'h00, "flags");
    rd(ctl, 8'h00, "control");
    rd(cnt, 8'h00, "count");
    rd(16'h0001, 8'h00, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_count();
    int n;
    wb(1'b1, cnt, 8'h55);
    rd(cnt, 8'h00, "count write");
    wb(1'b1, ctl, 8'h01);
    rd(ctl, 8'h01, "run");
    ticks(4100);
    rd(flg, 8'h70, "all factors");
    wb(1'b0, cnt, 8'h00);
    c0 = rv;
    n = 0;
    do begin
      wb(1'b0, cnt, 8'h00);
      n++;
    end while (rv === c0 && n < 40);
    chk(8'(rv !== c0), 8'h01, "count steps");
    if (rv === c0) begin
      test_done();
    end
    c0 = rv;
    wb(1'b1, ctl, 8'h00);
    rd(ctl, 8'h01, "stopping");
    ticks(100);
    rd(cnt, bcd_inc(c0), "last step");
    rd(ctl, 8'h00, "stopped");
    ticks(100);
    rd(cnt, bcd_inc(c0), "held");
    wb(1'b1, flg, 8'h00);
    rd(flg, 8'h70, "w0 flags");
    wb(1'b1, flg, 8'h70);
    rd(flg, 8'h00, "w1 flags");
    $display("test count done");
  endtask : t_count
  task automatic t_clear();
    wb(1'b1, ctl, 8'h02);
    rd(cnt, 8'h00, "clear stopped");
    rd(ctl, 8'h00, "clear reads");
    ticks(100);
    rd(cnt, 8'h00, "zero held");
    wb(1'b1, ctl, 8'h01);
    ticks(200);
    wb(1'b1, ctl, 8'h03);
    rd(cnt, 8'h00, "clear running");
    ticks(100);
    rd(cnt, 8'h02, "restarted");
    wb(1'b1, ctl, 8'h00);
    ticks(100);
    wb(1'b1, ctl, 8'h02);
    wb(1'b1, flg, 8'h70);
    $display("test clear done");
  endtask : t_clear
  task automatic t_irq();
    int n;
    wb(1'b1, pri, 8'h0C);
    rd(pri, 8'h0C, "prio");
    wb(1'b1, ena, 8'h40);
    rd(ena, 8'h40, "enables");
    wb(1'b1, ctl, 8'h01);
    n = 0;
    while (req !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk({4'h0, irq, req, lvl}, 8'h0F, "request");
    if (req !== 1'b1) begin
      test_done();
    end
    ticks(200);
    chk({4'h0, irq, req, lvl}, 8'h08, "masked");
    chk(8'(taken), 8'h01, "taken");
    wb(1'b1, ctl, 8'h00);
    ticks(100);
    wb(1'b1, flg, 8'h70);
    @(posedge mclk);
    mask <= 2'h0;
    mask_wr <= 1'b1;
    @(posedge mclk);
    mask_wr <= 1'b0;
    ticks(3);
    chk({4'h0, irq, req, lvl}, 8'h00, "cleared");
    wb(1'b1, pri, 8'h00);
    wb(1'b1, ctl, 8'h03);
    ticks(100);
    wb(1'b1, ctl, 8'h00);
    ticks(100);
    chk({4'h0, irq, req, lvl}, 8'h08, "level 0");
    chk(8'(taken), 8'h01, "no take");
    wb(1'b1, ena, 8'h00);
    ticks(3);
    chk({4'h0, irq, req, lvl}, 8'h00, "disabled");
    rd(flg, 8'h40, "flag kept");
    $display("test irq done");
  endtask : t_irq
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_count();
    t_clear();
    t_irq();
    test_done();
  end
endmodule : swt_top_tb
`default_nettype wire
